// file: supply_filter.sv
// glitch filter for one comparator output
// assumes the input is already synchronised to clk
`timescale 1ns/1ps
module supply_filter
    import wdt_psm_pkg::*;
#(
    parameter int HOLD = GLITCH_CYCLES
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic raw,
    output logic      clean
);
    initial if (HOLD < 1 || HOLD > 65535) $error("HOLD out of range");
    logic [15:0] cnt_q;
    // output follows the input only after it held steady for HOLD cycles
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 16'h0_000;
            clean <= 1'b1;
        end else if (raw == clean) begin
            cnt_q <= 16'h0_000;
        end else if (cnt_q == 16'(HOLD - 1)) begin
            cnt_q <= 16'h0_000;
            clean <= raw;
        end else begin
            cnt_q <= cnt_q + 16'h0_001;
        end
    end
endmodule

// file: watchdog_supply_monitor.sv
// watchdog with write unlock plus supply monitor interrupt flag
// assumes a core sfr port: one-cycle write strobe, combinational read data
`timescale 1ns/1ps
module watchdog_supply_monitor
    import wdt_psm_pkg::*;
#(
    parameter int GOOD_TICKS = GOOD_CYCLES,
    parameter int TB_CYCLES  = TB_DIV
) (
    input  wire logic       CLOCK,
    input  wire logic       NRST,
    input  wire logic [7:0] SFR_ADDR,
    input  wire logic       SFR_WR,
    input  wire logic [7:0] SFR_WDATA,
    output logic      [7:0] SFR_RDATA,
    input  wire logic       ANALOG_SUPPLY_OK,
    input  wire logic       DIGITAL_SUPPLY_OK,
    output logic      [1:0] ANALOG_TRIP_SEL,
    output logic      [1:0] DIGITAL_TRIP_SEL,
    output logic            SUPPLY_MONITOR_ON,
    input  wire logic       SUPPLY_IRQ_ENABLE,
    output logic            SUPPLY_IRQ,
    output logic            WDT_NMI,
    output logic            WDT_RESET
);
    initial if (GOOD_TICKS < 1 || TB_CYCLES < 1) $error("count parameters must be positive");

    logic        rs1_q, rst_n;
    logic [1:0]  a_sync_q, d_sync_q;
    logic        a_ok, d_ok;
    logic [3:0]  pre_q;
    logic        rsp_q, sts_q, arm_q, unl_q;
    logic [1:0]  dtrip_q, atrip_q;
    logic        on_q, irq_q;
    logic [31:0] tb_q;
    logic [15:0] wd_cnt_q, wd_lim;
    logic        tick, timed, expire, wd_wr, ps_wr, psm_irq_evt;
    logic [31:0] good_q;
    logic        wd_rst_q;

    // reset release through two flops
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            rs1_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rs1_q <= 1'b1;
            rst_n <= rs1_q;
        end
    end

    // comparator pins come from the analog domain
    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            a_sync_q <= 2'h3;
            d_sync_q <= 2'h3;
        end else begin
            a_sync_q <= {a_sync_q[0], ANALOG_SUPPLY_OK};
            d_sync_q <= {d_sync_q[0], DIGITAL_SUPPLY_OK};
        end
    end

    supply_filter u_afilt (.clk(CLOCK), .rst_n(rst_n), .raw(a_sync_q[1]), .clean(a_ok));
    supply_filter u_dfilt (.clk(CLOCK), .rst_n(rst_n), .raw(d_sync_q[1]), .clean(d_ok));

    // the unlock only opens the very next sfr write, and only if that write goes to the control register
    assign wd_wr = SFR_WR && SFR_ADDR == WDCTL_ADDR && unl_q;
    assign ps_wr = SFR_WR && SFR_ADDR == PSMCTL_ADDR;
    assign psm_irq_evt = irq_q && SUPPLY_IRQ_ENABLE;

    // 16-bit tick counter; 2^(pre) * 512 ticks of 32.768 kHz
    always_comb begin
        wd_lim = 16'h0_000;
        if (pre_q <= 4'h0_007)
            wd_lim = 16'((32'd512 << pre_q) - 32'd1);
    end
    assign tick   = (tb_q == 32'(TB_CYCLES - 1));
    // reserved codes leave the limit at zero, so they must never reach the compare
    assign timed  = tick && pre_q <= 4'h0_007 && wd_cnt_q == wd_lim;
    assign expire = arm_q && (pre_q == PRE_IMMEDIATE || timed);

    // time base prescaler and watchdog counter, restarted on every re-arm
    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            tb_q     <= 32'h0000_0000;
            wd_cnt_q <= 16'h0_000;
        end else if (wd_wr || !arm_q || expire) begin
            tb_q     <= 32'h0000_0000;
            wd_cnt_q <= 16'h0_000;
        end else begin
            tb_q <= tick ? 32'h0000_0000 : tb_q + 32'h0000_0001;
            if (tick)
                wd_cnt_q <= wd_cnt_q + 16'h0_001;
        end
    end

    // watchdog control register; a watchdog reset leaves status untouched
    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            pre_q <= WDCTL_RESET[7:WD_PRE_LSB];
            rsp_q <= WDCTL_RESET[WD_RSP_BIT];
            sts_q <= WDCTL_RESET[WD_STS_BIT];
            arm_q <= WDCTL_RESET[WD_ARM_BIT];
            unl_q <= WDCTL_RESET[WD_UNL_BIT];
        end else begin
            // unlock lasts for one write only
            if (SFR_WR)
                unl_q <= SFR_ADDR == WDCTL_ADDR && !unl_q && SFR_WDATA[WD_UNL_BIT];
            if (wd_wr) begin
                pre_q <= SFR_WDATA[7:WD_PRE_LSB];
                rsp_q <= SFR_WDATA[WD_RSP_BIT];
                sts_q <= SFR_WDATA[WD_STS_BIT];
                arm_q <= SFR_WDATA[WD_ARM_BIT];
            end
            if (expire) begin
                sts_q <= 1'b1; // set wins over a same-cycle clear
                if (!rsp_q || pre_q == PRE_IMMEDIATE)
                    arm_q <= 1'b0;
            end
            if (psm_irq_evt)
                arm_q <= 1'b0;
        end
    end

    // timeout response: reset pulse or unmaskable interrupt
    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            wd_rst_q <= 1'b0;
            WDT_NMI  <= 1'b0;
        end else begin
            wd_rst_q <= expire && (!rsp_q || pre_q == PRE_IMMEDIATE);
            WDT_NMI  <= expire && rsp_q && pre_q != PRE_IMMEDIATE;
        end
    end
    assign WDT_RESET = wd_rst_q;

    // supply monitor control and fault flag
    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            dtrip_q <= PSMCTL_RESET[PS_DTRIP_LSB +: 2];
            atrip_q <= PSMCTL_RESET[PS_ATRIP_LSB +: 2];
            on_q    <= PSMCTL_RESET[PS_ON_BIT];
            irq_q   <= PSMCTL_RESET[PS_IRQ_BIT];
            good_q  <= 32'h0000_0000;
        end else begin
            if (ps_wr) begin
                dtrip_q <= SFR_WDATA[PS_DTRIP_LSB +: 2];
                atrip_q <= SFR_WDATA[PS_ATRIP_LSB +: 2];
                on_q    <= SFR_WDATA[PS_ON_BIT];
            end
            if (!on_q) begin
                good_q <= 32'h0000_0000;
                if (ps_wr)
                    irq_q <= SFR_WDATA[PS_IRQ_BIT];
            end else if (!a_ok || !d_ok) begin
                irq_q  <= 1'b1;
                good_q <= 32'h0000_0000;
            end else begin
                if (ps_wr)
                    irq_q <= SFR_WDATA[PS_IRQ_BIT];
                if (irq_q && !(ps_wr && !SFR_WDATA[PS_IRQ_BIT])) begin
                    if (good_q == 32'(GOOD_TICKS - 1)) begin
                        irq_q  <= 1'b0;
                        good_q <= 32'h0000_0000;
                    end else begin
                        good_q <= good_q + 32'h0000_0001;
                    end
                end else begin
                    good_q <= 32'h0000_0000;
                end
            end
        end
    end

    assign SUPPLY_IRQ        = psm_irq_evt;
    assign ANALOG_TRIP_SEL   = atrip_q;
    assign DIGITAL_TRIP_SEL  = dtrip_q;
    assign SUPPLY_MONITOR_ON = on_q;

    // register read-back; comparator bits show live filtered state
    always_comb begin
        SFR_RDATA = 8'h00_00;
        if (SFR_ADDR == WDCTL_ADDR)
            SFR_RDATA = {pre_q, rsp_q, sts_q, arm_q, unl_q};
        else if (SFR_ADDR == PSMCTL_ADDR)
            SFR_RDATA = {d_ok, a_ok, irq_q, dtrip_q, atrip_q, on_q};
    end

    AST_STS_ON_EXPIRE: assert property (@(posedge CLOCK) disable iff (!rst_n)
        expire |=> sts_q) else $error("status not set after timeout");
    AST_NMI_RSP: assert property (@(posedge CLOCK) disable iff (!rst_n)
        (expire && rsp_q && pre_q != PRE_IMMEDIATE) |=> WDT_NMI && !WDT_RESET)
        else $error("interrupt response wrong");
    AST_RST_RSP: assert property (@(posedge CLOCK) disable iff (!rst_n)
        (expire && !rsp_q) |=> WDT_RESET && !arm_q) else $error("reset response wrong");
    AST_LOCKED: assert property (@(posedge CLOCK) disable iff (!rst_n)
        (SFR_WR && SFR_ADDR == WDCTL_ADDR && !unl_q && !expire && !psm_irq_evt)
        |=> $stable(arm_q) && $stable(pre_q)) else $error("locked write took effect");
    AST_PSM_DISARM: assert property (@(posedge CLOCK) disable iff (!rst_n)
        psm_irq_evt |=> !arm_q) else $error("supply interrupt did not disarm");
    AST_FAULT_SET: assert property (@(posedge CLOCK) disable iff (!rst_n)
        (on_q && !a_ok) |=> irq_q) else $error("fault not flagged");
    AST_NO_CLEAR_LOW: assert property (@(posedge CLOCK) disable iff (!rst_n)
        (on_q && irq_q && !d_ok) |=> irq_q) else $error("flag cleared while low");
    AST_GOOD_RESTART: assert property (@(posedge CLOCK) disable iff (!rst_n)
        (on_q && irq_q && !(a_ok && d_ok)) |=> good_q == 32'h0000_0000)
        else $error("good interval not restarted");
    AST_IRQ_GATE: assert property (@(posedge CLOCK) disable iff (!rst_n)
        (on_q && (!a_ok || !d_ok)) ##1 SUPPLY_IRQ_ENABLE |-> SUPPLY_IRQ)
        else $error("fault did not reach the core");
    // watchdog side: reserved codes stay quiet, immediate code fires at once
    AST_RESERVED_QUIET: assert property (@(posedge CLOCK) disable iff (!rst_n)
        (pre_q > PRE_IMMEDIATE) |-> !expire) else $error("reserved code timed out");
    AST_IMMEDIATE: assert property (@(posedge CLOCK) disable iff (!rst_n)
        (arm_q && pre_q == PRE_IMMEDIATE) |=> WDT_RESET && !arm_q)
        else $error("no immediate reset");
    AST_REARM_RESTART: assert property (@(posedge CLOCK) disable iff (!rst_n)
        wd_wr |=> wd_cnt_q == 16'h0_000 && tb_q == 32'h0000_0000)
        else $error("re-arm did not restart the counters");
    AST_STS_HOLD: assert property (@(posedge CLOCK) disable iff (!rst_n)
        (!wd_wr && !expire) |=> $stable(sts_q)) else $error("status changed on its own");
    AST_MON_OFF_HOLD: assert property (@(posedge CLOCK) disable iff (!rst_n)
        (!on_q && !ps_wr) |=> $stable(irq_q)) else $error("idle monitor moved its flag");
endmodule

// file: watchdog_supply_monitor_bench.sv
// self-checking bench for the watchdog and supply-monitor block
// assumes shortened good-supply and time-base counts handed in as parameters
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin errors++; \
    $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module watchdog_supply_monitor_bench;
    import wdt_psm_pkg::*;
    logic       clk = 0, nrst = 0, wr_en = 0, a_ok = 1, d_ok = 1, irq_en = 1;
    logic [7:0] addr = 0, wdata = 0, rdata;
    logic [1:0] ana_sel, dig_sel, tr, exp_v;
    logic       mon_on, sup_irq, wdt_nmi, wdt_rst;
    logic [1:0] exp_q[$];      // pending pulse notes as {nmi, reset}
    int         errors = 0, cmp_count = 0, i;
    int         seed = 32'h7358_1d12;

    watchdog_supply_monitor #(.GOOD_TICKS(50), .TB_CYCLES(4)) dut (
        .CLOCK             (clk),
        .NRST              (nrst),
        .SFR_ADDR          (addr),
        .SFR_WR            (wr_en),
        .SFR_WDATA         (wdata),
        .SFR_RDATA         (rdata),
        .ANALOG_SUPPLY_OK  (a_ok),
        .DIGITAL_SUPPLY_OK (d_ok),
        .ANALOG_TRIP_SEL   (ana_sel),
        .DIGITAL_TRIP_SEL  (dig_sel),
        .SUPPLY_MONITOR_ON (mon_on),
        .SUPPLY_IRQ_ENABLE (irq_en),
        .SUPPLY_IRQ        (sup_irq),
        .WDT_NMI           (wdt_nmi),
        .WDT_RESET         (wdt_rst)
    );

    // 250 MHz clock
    always #2 clk = ~clk;

    // a pulse with no pending note is compared against "no pulse"
    always @(posedge clk) begin
        if (wdt_nmi === 1'b1 || wdt_rst === 1'b1) begin
            exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : 2'b00;
            `CHK("timeout pulse", exp_v, {wdt_nmi, wdt_rst})
        end
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1 wr_en = 1;
        addr = a;
        wdata = d;
        @(posedge clk);
        #1 wr_en = 0;
    endtask

    // unlock then the real write, as software must always do it
    task automatic unl(input logic [7:0] d);
        wr(WDCTL_ADDR, 8'h00_01);
        wr(WDCTL_ADDR, d);
    endtask

    task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        #1 addr = a;
        #1 `CHK(nm, e, rdata)
    endtask

    // bounded wait for all pulse notes to be consumed
    task automatic wait_q(input int n);
        for (int k = 0; k < n && exp_q.size() > 0; k++) begin
            @(posedge clk);
        end
        `CHK("pulses pending", 0, exp_q.size())
    endtask

    task automatic finish_test;
        $display("comparisons %0d errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // hang guard: the sequence needs roughly 7.5k cycles
    initial begin
        #(60000 * 4);
        errors++;
        finish_test();
    end

    initial begin
        repeat (12) @(posedge clk);
        #1 nrst = 1;
        repeat (3) @(posedge clk);
        rd("wdctl reset", WDCTL_ADDR, WDCTL_RESET);
        rd("psmctl reset", PSMCTL_ADDR, PSMCTL_RESET);
        rd("unmapped", 8'h00_A5, 8'h00_00);
        wr(WDCTL_ADDR, 8'h00_02);
        rd("locked write", WDCTL_ADDR, 8'h00_10);
        unl(8'h00_02);
        rd("armed", WDCTL_ADDR, 8'h00_02);
        // refresh past half the interval, then outlive the first deadline
        repeat (1500) @(posedge clk);
        unl(8'h00_02);
        repeat (1500) @(posedge clk);
        exp_q.push_back(2'b01);
        wait_q(1000);
        rd("after reset", WDCTL_ADDR, 8'h00_04);
        unl(8'h00_0A);
        rd("status cleared", WDCTL_ADDR, 8'h00_0A);
        exp_q.push_back(2'b10);
        wait_q(3000);
        rd("after nmi", WDCTL_ADDR, 8'h00_0E);
        unl(8'h00_00);
        rd("disarmed", WDCTL_ADDR, 8'h00_00);
        exp_q.push_back(2'b01);
        unl(8'h00_82);
        wait_q(50);
        rd("immediate", WDCTL_ADDR, 8'h00_84);
        // a reserved code sits armed; any pulse here has no note and fails
        unl(8'h00_92);
        repeat (100) @(posedge clk);
        rd("reserved", WDCTL_ADDR, 8'h00_92);
        unl(8'h00_72);
        // trip selects, analog walking all codes, digital random
        for (i = 0; i < 4; i++) begin
            tr = 2'($random(seed));
            wr(PSMCTL_ADDR, {3'b110, tr, i[1:0], 1'b0});
            `CHK("trip sel", {tr, i[1:0]}, {dig_sel, ana_sel})
        end
        wr(PSMCTL_ADDR, 8'h00_00);
        `CHK("monitor off pin", 1'b0, mon_on)
        rd("flag cleared", PSMCTL_ADDR, 8'h00_C0);
        @(posedge clk);
        #1 a_ok = 0;
        repeat (400) @(posedge clk);
        #1 a_ok = 1;
        repeat (300) @(posedge clk);
        rd("monitor off", PSMCTL_ADDR, 8'h00_C0);
        wr(PSMCTL_ADDR, 8'h00_01);
        `CHK("monitor on pin", 1'b1, mon_on)
        @(posedge clk);
        #1 a_ok = 0;
        repeat (20) @(posedge clk);
        #1 a_ok = 1;
        repeat (300) @(posedge clk);
        rd("glitch", PSMCTL_ADDR, 8'h00_C1);
        @(posedge clk);
        #1 d_ok = 0;
        repeat (300) @(posedge clk);
        rd("digital low", PSMCTL_ADDR, 8'h00_61);
        `CHK("supply irq", 1'b1, sup_irq)
        rd("arm dropped", WDCTL_ADDR, 8'h00_70);
        wr(PSMCTL_ADDR, 8'h00_01);
        rd("clear refused", PSMCTL_ADDR, 8'h00_61);
        // dropping the enable hides the request while the flag stays
        @(posedge clk);
        #1 irq_en = 0;
        #1 `CHK("supply irq masked", 1'b0, sup_irq)
        @(posedge clk);
        #1 irq_en = 1;
        d_ok = 1;
        repeat (270) @(posedge clk);
        rd("still held", PSMCTL_ADDR, 8'h00_E1);
        repeat (60) @(posedge clk);
        rd("released", PSMCTL_ADDR, 8'h00_C1);
        `CHK("supply irq off", 1'b0, sup_irq)
        // a hardware reset mid-run clears the status that a timeout keeps
        unl(8'h00_04);
        rd("status set", WDCTL_ADDR, 8'h00_04);
        @(posedge clk);
        #1 nrst = 0;
        repeat (2) @(posedge clk);
        #1 nrst = 1;
        repeat (3) @(posedge clk);
        rd("hw reset wd", WDCTL_ADDR, WDCTL_RESET);
        rd("hw reset psm", PSMCTL_ADDR, PSMCTL_RESET);
        finish_test();
    end
endmodule

// file: wdt_psm_pkg.sv
// constants shared by the watchdog and supply-monitor logic
// assumes a 250 MHz core clock and an sfr-style byte register port
package wdt_psm_pkg;
    localparam logic [7:0]  WDCTL_ADDR      = 8'h00_C0;
    localparam logic [7:0]  WDCTL_RESET     = 8'h00_10;
    localparam logic [7:0]  PSMCTL_ADDR     = 8'h00_DF;
    localparam logic [7:0]  PSMCTL_RESET    = 8'h00_DE;
    localparam int          WD_PRE_LSB      = 4;
    localparam int          WD_RSP_BIT      = 3;
    localparam int          WD_STS_BIT      = 2;
    localparam int          WD_ARM_BIT      = 1;
    localparam int          WD_UNL_BIT      = 0;
    localparam int          PS_DOK_BIT      = 7;
    localparam int          PS_AOK_BIT      = 6;
    localparam int          PS_IRQ_BIT      = 5;
    localparam int          PS_DTRIP_LSB    = 3;
    localparam int          PS_ATRIP_LSB    = 1;
    localparam int          PS_ON_BIT       = 0;
    localparam logic [3:0]  PRE_IMMEDIATE   = 4'h0_008;
    localparam longint      CLK_HZ          = 250_000_000;
    localparam longint      TB_HZ_X1000     = 32_768_000;  // time base in mHz
    // cycles per 32.768 kHz tick, rounded down
    localparam int          TB_DIV          = int'((CLK_HZ * 1000) / TB_HZ_X1000);
    localparam int          GOOD_MS         = 250;
    localparam int          GOOD_CYCLES     = int'(CLK_HZ / 1000 * GOOD_MS);
    localparam int          GLITCH_NS       = 1000;
    localparam int          GLITCH_CYCLES   = int'(CLK_HZ / 1_000_000 * GLITCH_NS / 1000);
endpackage
